/* File: core/dcc_defs.vh */
/*
 * Constants for the dual comparator control block: register offsets,
 * field positions and reset values.
 * Assumes a 32-bit Avalon-MM slave with word-aligned registers.
 */
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

`define DCC_OFS_ONE_MAIN     4'h0
`define DCC_OFS_ONE_INPUTS   4'h1
`define DCC_OFS_TWO_MAIN     4'h2
`define DCC_OFS_TWO_INPUTS   4'h3
`define DCC_OFS_MIRROR       4'h4
`define DCC_OFS_IRQ_FLAGS    4'h5
`define DCC_OFS_PORT_CTRL    4'h6
`define DCC_OFS_PORT_READ    4'h7

`define DCC_BIT_ENABLE       7
`define DCC_BIT_RESULT       6
`define DCC_BIT_PIN_OE       5
`define DCC_BIT_INVERT       4
`define DCC_BIT_SPEED        2
`define DCC_BIT_HYST         1
`define DCC_BIT_SYNC         0
`define DCC_BIT_RISE_IE      7
`define DCC_BIT_FALL_IE      6
`define DCC_POS_CH_HI        5
`define DCC_POS_CH_LO        4
`define DCC_BIT_NEG_CH       0

`define DCC_MAIN_WMASK       8'hB7
`define DCC_INPUTS_WMASK     8'hF1
`define DCC_MAIN_RESET       8'h04
`define DCC_INPUTS_RESET     8'h00

`endif

/* File: core/dcc_top.v */
/*
 * Dual comparator control: control registers, result conditioning,
 * timer-synchronous output latch, edge interrupt flags and port read mask.
 * Assumes analog results arrive synchronous to ref_clk and the prescaled
 * timer clock is a sampled level input.
 */
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.vh"

module dcc_top (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [1:0]  analog_compare_raw,
    input  wire        timer_clk_prescaled,
    input  wire [1:0]  pin_direction_bit,
    input  wire [7:0]  port_pin_levels,
    output reg  [1:0]  cmp_enable,
    output reg  [1:0]  cmp_speed_power_select,
    output reg  [1:0]  cmp_hysteresis_enable,
    output reg  [3:0]  cmp_positive_channel_field,
    output reg  [1:0]  cmp_negative_channel_select,
    output reg  [1:0]  cmp_timer_result,
    output reg  [1:0]  cmp_pin_out,
    output reg  [1:0]  cmp_pin_oe_n,
    output reg  [1:0]  complementary_output_generator,
    output reg  [1:0]  cmp_irq_flag
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0] main_reg [0:1];
reg  [7:0] inputs_reg [0:1];
reg  [7:0] analog_pin_select_reg;
reg  [1:0] result_reg;
reg  [1:0] result_prev_reg;
reg  [1:0] sync_hold_reg;
reg        tclk_prev_reg;
reg        ack_reg;

// A write lands at the answer edge, where the master sees waitrequest low
wire       wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
wire       rd_go = avs_read && avs_waitrequest && !ack_reg;
wire [3:0] word_idx = avs_address[5:2];
wire [7:0] wbyte = avs_writedata[7:0];
wire       tclk_fall = tclk_prev_reg && !timer_clk_prescaled;

wire [1:0] cond_now;
wire [1:0] rise_evt;
wire [1:0] fall_evt;
wire [1:0] clr_req;
wire [1:0] sync_sel;
wire [1:0] delivered;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
        // A disabled comparator outputs low before polarity
        assign cond_now[g] = (main_reg[g][`DCC_BIT_ENABLE] & analog_compare_raw[g])
                             ^ main_reg[g][`DCC_BIT_INVERT];
        // Edge of the registered status versus last cycle
        assign rise_evt[g] = result_reg[g] & ~result_prev_reg[g]
                             & inputs_reg[g][`DCC_BIT_RISE_IE];
        assign fall_evt[g] = ~result_reg[g] & result_prev_reg[g]
                             & inputs_reg[g][`DCC_BIT_FALL_IE];
        assign clr_req[g] = wr_go && (word_idx == `DCC_OFS_IRQ_FLAGS) && wbyte[g];
        assign sync_sel[g] = main_reg[g][`DCC_BIT_SYNC];
        // Async path follows cond directly; sync path holds latched value
        assign delivered[g] = sync_sel[g] ? sync_hold_reg[g] : cond_now[g];
    end
endgenerate

integer i;
integer j;

////////////////////////////////////////////////////////////////////////////////
// Register writes and state

always @(posedge ref_clk) begin
    if (reset) begin
        for (i = 0; i < 2; i = i + 1) begin
            main_reg[i]   <= `DCC_MAIN_RESET;
            inputs_reg[i] <= `DCC_INPUTS_RESET;
        end
        analog_pin_select_reg <= 8'h00;
        result_reg      <= 2'h0;
        result_prev_reg <= 2'h0;
        sync_hold_reg   <= 2'h0;
        tclk_prev_reg   <= 1'b0;
        cmp_irq_flag    <= 2'h0;
    end else begin
        if (wr_go) begin
            case (word_idx)
                `DCC_OFS_ONE_MAIN:   main_reg[0]   <= wbyte & `DCC_MAIN_WMASK;
                `DCC_OFS_TWO_MAIN:   main_reg[1]   <= wbyte & `DCC_MAIN_WMASK;
                `DCC_OFS_ONE_INPUTS: inputs_reg[0] <= wbyte & `DCC_INPUTS_WMASK;
                `DCC_OFS_TWO_INPUTS: inputs_reg[1] <= wbyte & `DCC_INPUTS_WMASK;
                `DCC_OFS_PORT_CTRL:  analog_pin_select_reg <= wbyte;
                default: ;
            endcase
        end
        result_reg      <= cond_now;
        result_prev_reg <= result_reg;
        tclk_prev_reg   <= timer_clk_prescaled;
        // Latch on falling edge of the prescaled timer clock
        if (tclk_fall)
            sync_hold_reg <= cond_now;
        // Write-one-to-clear; a same-cycle edge keeps the flag
        cmp_irq_flag <= (cmp_irq_flag & ~clr_req) | rise_evt | fall_evt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs to analog cores, timer, pins and output generator

always @(posedge ref_clk) begin
    if (reset) begin
        cmp_enable                     <= 2'h0;
        cmp_speed_power_select         <= 2'h3;
        cmp_hysteresis_enable          <= 2'h0;
        cmp_positive_channel_field     <= 4'h0;
        cmp_negative_channel_select    <= 2'h0;
        cmp_timer_result               <= 2'h0;
        cmp_pin_out                    <= 2'h0;
        cmp_pin_oe_n                   <= 2'h3;
        complementary_output_generator <= 2'h0;
    end else begin
        for (j = 0; j < 2; j = j + 1) begin
            cmp_enable[j]             <= main_reg[j][`DCC_BIT_ENABLE];
            cmp_speed_power_select[j] <= main_reg[j][`DCC_BIT_SPEED];
            cmp_hysteresis_enable[j]  <= main_reg[j][`DCC_BIT_HYST];
            cmp_negative_channel_select[j] <= inputs_reg[j][`DCC_BIT_NEG_CH];
            // Pin drive ignores the enable bit, needs direction cleared
            cmp_pin_oe_n[j] <= ~(main_reg[j][`DCC_BIT_PIN_OE] & ~pin_direction_bit[j]);
        end
        cmp_positive_channel_field <= {inputs_reg[1][`DCC_POS_CH_HI:`DCC_POS_CH_LO],
                                       inputs_reg[0][`DCC_POS_CH_HI:`DCC_POS_CH_LO]};
        // The output stage adds one flop so ports come straight from registers
        cmp_timer_result <= delivered;
        cmp_pin_out      <= delivered;
        complementary_output_generator <= result_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle, then ack

function [7:0] status_view;
    input [7:0] m;
    input       r;
    begin
        status_view = m;
        status_view[`DCC_BIT_RESULT] = r;
    end
endfunction

reg [7:0] rd_byte;
always @* begin
    case (word_idx)
        `DCC_OFS_ONE_MAIN:   rd_byte = status_view(main_reg[0], result_reg[0]);
        `DCC_OFS_TWO_MAIN:   rd_byte = status_view(main_reg[1], result_reg[1]);
        `DCC_OFS_ONE_INPUTS: rd_byte = inputs_reg[0];
        `DCC_OFS_TWO_INPUTS: rd_byte = inputs_reg[1];
        `DCC_OFS_MIRROR:     rd_byte = {6'h00, result_reg[1], result_reg[0]};
        `DCC_OFS_IRQ_FLAGS:  rd_byte = {6'h00, cmp_irq_flag};
        `DCC_OFS_PORT_CTRL:  rd_byte = analog_pin_select_reg;
        `DCC_OFS_PORT_READ:  rd_byte = port_pin_levels & ~analog_pin_select_reg;
        default:             rd_byte = 8'h00;
    endcase
end

always @(posedge ref_clk) begin
    if (reset) begin
        ack_reg         <= 1'b0;
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h00000000;
    end else begin
        ack_reg         <= rd_go || (avs_write && avs_waitrequest && !ack_reg);
        avs_waitrequest <= !(rd_go || (avs_write && avs_waitrequest && !ack_reg));
        if (rd_go)
            avs_readdata <= {24'h000000, rd_byte};
    end
end

endmodule
`default_nettype wire

/* File: testbench/dcc_props.sv */
/* Port-level checker for dcc_top: bus answer timing, pin drive, flags.
   Bound to every dcc_top instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dcc_props (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  pin_direction_bit,
    input wire logic [1:0]  cmp_enable,
    input wire logic [1:0]  cmp_speed_power_select,
    input wire logic [1:0]  cmp_pin_oe_n,
    input wire logic [1:0]  complementary_output_generator,
    input wire logic [1:0]  cmp_irq_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_speed_reset: assert property ($fell(reset) |-> cmp_speed_power_select == 2'h3)
        else $error("speed select not one after reset");
    a_input_no_drive: assert property ($past(pin_direction_bit[0]) && $past(pin_direction_bit[0], 2) |-> cmp_pin_oe_n[0])
        else $error("pin driven while input");
    a_flag_cause: assert property ($rose(cmp_irq_flag[0]) |-> complementary_output_generator[0] != $past(complementary_output_generator[0]) || $past(complementary_output_generator[0]) != $past(complementary_output_generator[0], 3))
        else $error("flag set without status edge");
    a_flag_clear: assert property ($fell(cmp_irq_flag[0]) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("flag cleared without write");
    a_enable_write: assert property ($changed(cmp_enable) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("enable changed without write");
    c_flag: cover property ($rose(cmp_irq_flag[0]));
    c_read: cover property (avs_read && !avs_waitrequest);
    c_drive: cover property ($fell(cmp_pin_oe_n[0]));
endmodule
bind dcc_top dcc_props u_props (.ref_clk, .reset, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .pin_direction_bit, .cmp_enable, .cmp_speed_power_select, .cmp_pin_oe_n,
    .complementary_output_generator, .cmp_irq_flag);
`default_nettype wire

/* File: testbench/dcc_analog_model.sv */
/* Far side: two analog comparator cores and a prescaled timer clock.
   The bench sets which core sees positive above negative. */
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model #(parameter int DLY = 2, parameter int TDIV = 20) (
    input  wire logic       ref_clk,
    input  wire logic [1:0] en,
    input  wire logic [1:0] above,
    output logic [1:0]      raw,
    output logic            tclk = 1'b0
);
    logic [7:0] sh = 8'h00;
    int         c = 0;
    // Response time of the core; a disabled core outputs low
    always @(posedge ref_clk) sh <= {sh[5:0], en & above};
    assign raw = sh[2*DLY-1 -: 2];
    always @(posedge ref_clk) begin
        c <= (c == TDIV - 1) ? 0 : c + 1;
        if (c == TDIV - 1) tclk <= ~tclk;
    end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
/* Self-checking bench for dcc_top over Avalon-MM with analog model.
   One clock at 100 MHz, synchronous reset for 10 cycles. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic ref_clk = 0, reset = 1, avs_read = 0, avs_write = 0;
    logic [5:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, timer_clk_prescaled;
    logic [1:0] analog_compare_raw, pin_direction_bit = 2'h3, above = 0, cmp_enable;
    logic [1:0] cmp_speed_power_select, cmp_hysteresis_enable, cmp_negative_channel_select;
    logic [1:0] cmp_timer_result, cmp_pin_out, cmp_pin_oe_n, complementary_output_generator;
    logic [1:0] cmp_irq_flag;
    logic [7:0] port_pin_levels = 0;
    logic [3:0] cmp_positive_channel_field;
    int n_mismatch = 0, n_compared = 0;
    dcc_top DUT (.*);
    dcc_analog_model u_model (.ref_clk, .en(cmp_enable), .above, .raw(analog_compare_raw),
        .tclk(timer_clk_prescaled));
    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input bit w, input [3:0] i, input [7:0] d, output [7:0] q);
        int k;
        k = 0;
        @(posedge ref_clk);
        avs_address <= {i, 2'h0}; avs_writedata <= {24'h0, d}; avs_write <= w; avs_read <= !w;
        do begin @(posedge ref_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) n_mismatch++;
        q = avs_readdata[7:0];
        avs_read <= 0; avs_write <= 0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic wr(input [3:0] i, input [7:0] d); logic [7:0] q; bus(1, i, d, q); endtask
    task automatic rchk(input [3:0] i, input [7:0] e); logic [7:0] q; bus(0, i, 0, q); `CHK(q, e) endtask
    task automatic wt(int n); repeat (n) @(posedge ref_clk); endtask
    task close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rchk(0, 8'h04);
        rchk(4, 8'h00);
        rchk(15, 8'h00);
        `CHK(cmp_speed_power_select, 2'h3)
        $display("reset test done");
    endtask
    task t_inputs;
        for (int p = 0; p < 4; p++) begin
            wr(1, {2'h3, p[1:0], 4'hF});
            rchk(1, {2'h3, p[1:0], 4'h1});
            `CHK(cmp_positive_channel_field[1:0], p[1:0])
            `CHK(cmp_negative_channel_select[0], 1'b1)
        end
        wr(1, 8'h00);
        `CHK(cmp_negative_channel_select[0], 1'b0)
        $display("input select test done");
    endtask
    task t_status;
        above <= 2'h1; wr(0, 8'h80); wt(4);
        rchk(0, 8'hC0);
        rchk(4, 8'h01);
        `CHK(complementary_output_generator[0], 1'b1)
        `CHK(cmp_speed_power_select[0], 1'b0)
        wr(0, 8'hFF); wt(4);
        rchk(0, 8'hB7);
        `CHK(cmp_hysteresis_enable[0], 1'b1)
        `CHK(cmp_pin_oe_n[0], 1'b1)
        pin_direction_bit <= 2'h0; wt(3);
        `CHK(cmp_pin_oe_n[0], 1'b0)
        wr(2, 8'h80); above <= 2'h3; wt(5);
        rchk(4, 8'h02);
        $display("status test done");
    endtask
    task t_sync;
        wr(0, 8'hA1); above <= 2'h2;
        @(posedge timer_clk_prescaled); @(negedge timer_clk_prescaled); wt(4);
        above <= 2'h3; wt(8);
        `CHK(cmp_timer_result[0], 1'b0)
        @(negedge timer_clk_prescaled); wt(4);
        `CHK(cmp_timer_result[0], 1'b1)
        wr(0, 8'hA0); above <= 2'h2; wt(6);
        `CHK({cmp_timer_result[0], cmp_pin_out[0]}, 2'h0)
        $display("sync test done");
    endtask
    task t_irq;
        wr(5, 8'h03); wr(1, 8'h80); above <= 2'h3; wt(8);
        rchk(5, 8'h01);
        wr(5, 8'h01); rchk(5, 8'h00);
        above <= 2'h2; wt(8); rchk(5, 8'h00);
        wr(1, 8'h40); above <= 2'h3; wt(8); rchk(5, 8'h00);
        above <= 2'h2; wt(8); rchk(5, 8'h01);
        wr(5, 8'h01); wr(1, 8'hC0); wr(0, 8'h10); wt(4);
        rchk(5, 8'h01);
        wr(6, 8'h0F); port_pin_levels <= 8'hFF; wt(2);
        rchk(7, 8'hF0);
        $display("irq and port test done");
    endtask
    initial begin
        wt(10); reset <= 0;
        t_reset; t_inputs; t_status; t_sync; t_irq;
        close_out;
    end
    initial begin wt(5000); n_mismatch++; close_out; end
endmodule
`default_nettype wire
